// ---- src/otfm_top.sv ----
/*
  Over-temperature fault monitor: threshold and action registers behind a
  command port, fault detection with restart hysteresis, status flags, alert
  and output-enable control.
  Assumes the temperature word and command port come from logic on clk_i,
  so neither is synchronised here.
*/
`timescale 1ns/1ps
`include "otfm_map.svh"
module otfm_top
  import otfm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic [15:0] cmd_rdata_o,
  output logic cmd_ack_o,
  output logic cmd_error_o,
  input wire logic [15:0] temp_word_i,
  input wire logic status_clear_i,
  output logic status_byte_temp_o,
  output logic status_temp_ot_fault_o,
  output logic host_alert_out_o,
  output logic regulator_fault_out_o,
  output logic output_enable_o,
  output logic shutdown_o
);
  typedef struct packed {
    otfm_word_t threshold;
    logic shutdown;
    logic flag_byte_temp;
    logic flag_temp_fault;
    logic [15:0] rdata;
    logic ack;
    logic error;
  } otfm_state_t;

  otfm_state_t st_q;
  otfm_state_t st_d;

  otfm_dec_if dec_if[2] ();

  // channel 0 decodes the threshold, channel 1 the temperature reading
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_dec
      otfm_lin_decode u_dec (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .bus(dec_if[g])
      );
    end
  endgenerate

  assign dec_if[0].word = st_q.threshold;
  assign dec_if[1].word = temp_word_i;

  otfm_val_t thr_val;
  otfm_val_t temp_val;
  otfm_val_t hyst_val;
  otfm_val_t release_val;
  logic both_valid;
  logic over_limit;
  logic below_release;
  logic fault_trigger;

  // compare only once both decoders hold real data, else reset zeros would match
  assign thr_val = dec_if[0].value;
  assign temp_val = dec_if[1].value;
  assign both_valid = dec_if[0].valid & dec_if[1].valid;
  assign hyst_val = otfm_val_t'(`OTFM_HYST_DEGC) <<< `OTFM_FRAC_BITS;
  assign release_val = thr_val - hyst_val;
  assign over_limit = both_valid && (temp_val >= thr_val);
  assign below_release = both_valid && (temp_val <= release_val);
  assign fault_trigger = over_limit && !st_q.shutdown;

  // one process for registers, fault latch and flags
  always_comb begin
    st_d = st_q;
    st_d.ack = 1'b0;
    st_d.error = 1'b0;

    // command port: one-cycle ack, read data registered
    if (cmd_valid_i) begin
      st_d.ack = 1'b1;
      case (cmd_code_i)
        `OTFM_CMD_THRESHOLD: begin
          if (cmd_write_i) begin
            st_d.threshold = cmd_wdata_i;
          end else begin
            st_d.rdata = st_q.threshold;
          end
        end
        `OTFM_CMD_ACTION: begin
          // action is fixed; a write is refused and flagged
          if (cmd_write_i) begin
            st_d.error = 1'b1;
          end else begin
            st_d.rdata = {8'h00, `OTFM_ACTION_VALUE};
          end
        end
        default: begin
          st_d.error = 1'b1;
          if (!cmd_write_i) begin
            st_d.rdata = 16'h0000;
          end
        end
      endcase
    end

    // clear first so a fault in the same cycle still sets the flags
    if (status_clear_i) begin
      st_d.flag_byte_temp = 1'b0;
      st_d.flag_temp_fault = 1'b0;
    end

    // shutdown latch with hysteresis; restart needs a 15 degree drop
    if (fault_trigger) begin
      st_d.shutdown = 1'b1;
      st_d.flag_byte_temp = 1'b1;
      st_d.flag_temp_fault = 1'b1;
    end else if (st_q.shutdown && below_release) begin
      st_d.shutdown = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
      st_q.threshold <= `OTFM_THRESHOLD_RESET;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // alert stays until software clears; regulator fault also holds through shutdown
  assign host_alert_out_o = st_q.flag_byte_temp | st_q.flag_temp_fault;
  assign regulator_fault_out_o = st_q.flag_temp_fault | st_q.shutdown;
  assign output_enable_o = !st_q.shutdown;
  assign shutdown_o = st_q.shutdown;
  assign status_byte_temp_o = st_q.flag_byte_temp;
  assign status_temp_ot_fault_o = st_q.flag_temp_fault;
  assign cmd_rdata_o = st_q.rdata;
  assign cmd_ack_o = st_q.ack;
  assign cmd_error_o = st_q.error;
endmodule : otfm_top

// ---- src/otfm_map.svh ----
// What this block does
// - writable over-temperature fault threshold in degrees C, 125 after reset
// - threshold word: signed exponent in bits 15:11, signed mantissa in 10:0
// - on fault, set the temperature summary flag of the status byte
// - on fault, set the over-temperature fault flag of the temperature status
// - on fault, assert host alert and regulator fault outputs
// - on fault, shut down and disable the regulated output at once
// - restart automatically once temperature falls 15 degrees C below threshold
// - fault action reads as fixed, read-only 8-bit value f8h
/*
  Offsets, field positions, reset values and fixed-point constants of the
  over-temperature fault monitor. Assumes inclusion by bare name.
*/
`ifndef OTFM_MAP_SVH
`define OTFM_MAP_SVH

`define OTFM_CMD_THRESHOLD 8'h4f
`define OTFM_CMD_ACTION 8'h50
`define OTFM_THRESHOLD_RESET 16'h007d
`define OTFM_ACTION_VALUE 8'hf8
`define OTFM_EXP_MSB 15
`define OTFM_EXP_LSB 11
`define OTFM_MANT_MSB 10
`define OTFM_MANT_LSB 0
`define OTFM_FRAC_BITS 16
`define OTFM_HYST_DEGC 15

`endif

// ---- src/otfm_pkg.sv ----
/*
  Types of the over-temperature fault monitor.
  Assumes otfm_map.svh is on the include path.
*/
package otfm_pkg;
  // decoded linear value: 11-bit mantissa shifted by up to 31
  localparam int OTFM_VAL_W = 43;
  typedef logic signed [OTFM_VAL_W-1:0] otfm_val_t;
  typedef logic [15:0] otfm_word_t;
endpackage : otfm_pkg

// ---- src/otfm_dec_if.sv ----
/*
  Carrier between the monitor and its linear-format decoders.
  Assumes one decoder per instance of this interface.
*/
`timescale 1ns/1ps
interface otfm_dec_if;
  import otfm_pkg::*;
  otfm_word_t word;
  otfm_val_t value;
  logic valid;
  modport src (output word, input value, input valid);
  modport dec (input word, output value, output valid);
endinterface : otfm_dec_if

// ---- src/otfm_lin_decode.sv ----
/*
  Linear-format decoder: mantissa times two to the exponent, as a signed
  fixed-point value with a common number of fraction bits. Registered output.
  Assumes word is synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "otfm_map.svh"
module otfm_lin_decode
  import otfm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  otfm_dec_if.dec bus
);
  typedef struct packed {
    otfm_val_t value;
    logic valid;
  } otfm_dec_state_t;

  otfm_dec_state_t st_q;
  otfm_dec_state_t st_d;

  // exponent -16..15 plus 16 fraction bits never goes negative, so one left shift serves
  always_comb begin
    logic signed [4:0] exp_v;
    logic [5:0] shift_v;
    otfm_val_t mant_v;
    exp_v = 5'h00;
    shift_v = 6'h00;
    mant_v = '0;
    st_d = st_q;
    exp_v = $signed(bus.word[`OTFM_EXP_MSB:`OTFM_EXP_LSB]);
    shift_v = 6'({exp_v[4], exp_v}) + 6'(`OTFM_FRAC_BITS);
    mant_v = otfm_val_t'($signed(bus.word[`OTFM_MANT_MSB:`OTFM_MANT_LSB]));
    st_d.value = mant_v <<< shift_v;
    st_d.valid = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign bus.value = st_q.value;
  assign bus.valid = st_q.valid;
endmodule : otfm_lin_decode

// ---- bench/otfm_host_model.sv ----
/* host model: one-cycle command requests.
   assumes clk_i is the block clock */
`timescale 1ns/1ps
module otfm_host_model (
  input wire logic clk_i,
  output logic cmd_valid_o = 1'b0,
  output logic cmd_write_o = 1'b0,
  output logic [7:0] cmd_code_o = 8'h00,
  output logic [15:0] cmd_wdata_o = 16'h0000
);
  // idle code and data lines invert so stale data never looks valid
  task xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_i);
    #1 cmd_valid_o = 1'b1;
    {cmd_write_o, cmd_code_o, cmd_wdata_o} = {w, c, d};
    @(posedge clk_i);
    #1 cmd_valid_o = 1'b0;
    {cmd_code_o, cmd_wdata_o} = ~{c, d};
  endtask : xfer
endmodule : otfm_host_model

// ---- bench/otfm_top_sva.sv ----
/* checker on otfm_top ports.
   assumes the bind reaches every port by name */
`timescale 1ns/1ps
module otfm_top_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_rdata_o,
  input wire logic cmd_ack_o,
  input wire logic cmd_error_o,
  input wire logic status_byte_temp_o,
  input wire logic status_temp_ot_fault_o,
  input wire logic host_alert_out_o,
  input wire logic regulator_fault_out_o,
  input wire logic output_enable_o,
  input wire logic shutdown_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // action command taken, and the moment of shutdown
  sequence s_act; cmd_valid_i && ce_i && cmd_code_i == 8'h50; endsequence
  sequence s_trip; $fell(output_enable_o); endsequence
  chk_ack_next: assert property (cmd_valid_i && ce_i |=> cmd_ack_o)
    else $error("late ack");
  chk_ack_idle: assert property (ce_i && !cmd_valid_i |=> !cmd_ack_o)
    else $error("stray ack");
  chk_act_read: assert property (s_act ##0 !cmd_write_i |=> cmd_rdata_o == 16'h00f8)
    else $error("action value");
  chk_act_write: assert property (s_act ##0 cmd_write_i |=> cmd_error_o)
    else $error("action write");
  chk_byte_flag: assert property (s_trip |-> status_byte_temp_o)
    else $error("byte flag");
  chk_ot_flag: assert property (s_trip |-> status_temp_ot_fault_o)
    else $error("fault flag");
  chk_alert_pair: assert property (status_temp_ot_fault_o |-> host_alert_out_o && regulator_fault_out_o)
    else $error("alert");
  chk_shut_off: assert property (shutdown_o |-> !output_enable_o && regulator_fault_out_o)
    else $error("shutdown");
  chk_ce_freeze: assert property (!ce_i |=> $stable(shutdown_o) && $stable(status_byte_temp_o))
    else $error("enable freeze");
endmodule : otfm_top_sva
bind otfm_top otfm_top_sva otfm_top_sva_inst (.*);

// ---- bench/otfm_top_tb.sv ----
/* bench: host model issues commands, a queue checks acks.
   assumes ce_i high except for one stretch that shows the freeze */
`timescale 1ns/1ps
module otfm_top_tb;
  import otfm_pkg::*;
  logic clk_i = 0, rst_n_i = 0, ce_i = 1, status_clear_i = 0;
  logic cmd_valid_i, cmd_write_i, cmd_ack_o, cmd_error_o, shutdown_o, output_enable_o;
  logic status_byte_temp_o, status_temp_ot_fault_o, host_alert_out_o, regulator_fault_out_o;
  logic [7:0] cmd_code_i;
  otfm_word_t cmd_wdata_i, cmd_rdata_o, last = 0, temp_word_i = 0;
  logic [16:0] exp_q[$];
  logic [31:0] seed = 32'h7517;
  logic [5:0] stat;
  // status outputs in the order the heat steps list them
  assign stat = {shutdown_o, output_enable_o, status_byte_temp_o, status_temp_ot_fault_o,
    host_alert_out_o, regulator_fault_out_o};
  int n_fail = 0, comparisons = 0;
  otfm_top otfm_top_inst (.*);
  otfm_host_model otfm_host_model_inst (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i),
    .cmd_write_o(cmd_write_i), .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i));
  initial forever #5 clk_i = ~clk_i;
  task check(input logic [16:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %0t %h %h", $time, got, exp);
    end
  endtask : check
  task results;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  function logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // note the answer first; writes leave read data alone
  task cmd(input logic w, input logic [7:0] c, input otfm_word_t d, rd, input logic e);
    if (!w) last = rd;
    exp_q.push_back({e, last});
    otfm_host_model_inst.xfer(w, c, d);
  endtask : cmd
  // two edges of latency, one more of margin
  task heat(input otfm_word_t t, input logic clr, input logic [5:0] x);
    @(posedge clk_i);
    #1 {temp_word_i, status_clear_i} = {t, clr};
    repeat (3) @(posedge clk_i);
    #1 status_clear_i = 0;
    @(negedge clk_i) check(17'(stat), 17'(x));
  endtask : heat
  // every ack takes the oldest note
  always @(negedge clk_i) if (cmd_ack_o === 1'b1) check({cmd_error_o, cmd_rdata_o}, exp_q.pop_front());
  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_n_i = 1;
    cmd(1'b0, 8'h4f, '0, 16'h007d, 1'b0);
    cmd(1'b1, 8'h50, 16'h1234, '0, 1'b1);
    cmd(1'b0, 8'h50, '0, 16'h00f8, 1'b0);
    cmd(1'b0, 8'h33, '0, '0, 1'b1);
    repeat (4) begin
      seed = xs(seed);
      cmd(1'b1, 8'h4f, {6'h00, seed[9:0] | 10'h200}, '0, 1'b0);
      cmd(1'b0, 8'h4f, '0, {6'h00, seed[9:0] | 10'h200}, 1'b0);
    end
    cmd(1'b1, 8'h4f, 16'h0832, '0, 1'b0);
    heat(16'h0063, 1'b0, 6'b010000);
    heat(16'hf8c8, 1'b0, 6'b101111);
    heat(16'h0056, 1'b0, 6'b101111);
    heat(16'h0055, 1'b0, 6'b011111);
    heat(16'h0055, 1'b1, 6'b010000);
    // a frozen enable must hold off the trip, which lands once enable returns
    @(posedge clk_i) #1 ce_i = 0;
    heat(16'h0064, 1'b0, 6'b010000);
    @(posedge clk_i) #1 ce_i = 1;
    heat(16'h0064, 1'b0, 6'b101111);
    results();
  end
  // the run needs under a hundred cycles
  initial begin
    #50000;
    n_fail++;
    results();
  end
endmodule : otfm_top_tb
